// >>> irs_top.v
// input range select register bank with axi4-lite slave and per-input range outputs
//
// Operation
// RULE1: group A upper range register sits at index 0x05, resets to 0x00ff.
// RULE2: group B lower range register sits at index 0x06, resets to 0x00ff.
// RULE3: bits 15:9 carry the register's address; they reset to zero.
// RULE4: range code 00 and 11 give 10 V, 01 gives 2.5 V, 10 gives 5 V.
// RULE5: group A fields 7:6..1:0 set inputs seven..four, each resetting to 3.
// RULE6: group B fields 7:6..1:0 set inputs three..zero, each resetting to 3.
// RULE7: bit 8 is reserved, resets to zero and never affects range selection.
// RULE8: each field drives its own input, choosing one of exactly three ranges.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "irs_regs.vh"

module irs_top #(
   parameter ADDR_W = 8
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   output wire [2:0]        range_a_input_seven,
   output wire [2:0]        range_a_input_six,
   output wire [2:0]        range_a_input_five,
   output wire [2:0]        range_a_input_four,
   output wire [2:0]        range_b_input_three,
   output wire [2:0]        range_b_input_two,
   output wire [2:0]        range_b_input_one,
   output wire [2:0]        range_b_input_zero
);

   // register map, byte addresses on the bus
   //   0x14  group a upper range word, index 0x05
   //   0x18  group b lower range word, index 0x06
   //   0x20  read-only status, the eight applied ranges
   //   any other address answers slverr and changes nothing
   //
   // range word layout
   //   15:9  address field, zero after reset, stamped on every write
   //   8     reserved, kept as written, never reaches a range
   //   7:6   highest input of the group
   //   5:4   next input down
   //   3:2   next input down
   //   1:0   lowest input of the group
   //   only byte lanes 0 and 1 are stored; lanes 2 and 3 are dropped
   //   bits 31:16 of a range word read are zero; a status read has only bits 31:24 zero
   //
   // range codes and the one-hot outputs they give
   //   00  +/-10 V   -> 100
   //   01  +/-2.5 V  -> 001
   //   10  +/-5 V    -> 010
   //   11  +/-10 V   -> 100
   //   an output is never zero and never has two bits set
   //
   // write timing
   //   edge 0  address and data beats land, in either order
   //   edge 1  range word updated, bvalid rises with its response
   //   edge 2  applied range outputs follow the new word
   //   bvalid then stands until an edge sees bready high
   //   awready and wready stay low while a beat is held or bvalid is up,
   //   and for the cycle a beat lands, so a beat is never taken twice
   //   a second write may offer its beats at once; they wait for bvalid
   //   to fall and are then taken two edges later
   //
   // read timing
   //   edge 0  address taken, rdata and rresp loaded, rvalid rises
   //   rvalid and its payload stand until an edge sees rready high
   //   arready returns at the edge after rvalid falls
   //   the read path samples the range words directly, so a read in the
   //   cycle after a write already sees the new word
   //   an unmapped read returns zero data with slverr
   //
   // reset
   //   synchronous and active low; all ready and valid outputs drop,
   //   both words go to 0x00ff and every output shows +/-10 V
   //   ready outputs rise at the first edge with reset released, so the
   //   first request is taken at the second edge at the earliest
   //   a second reset in mid-run behaves like the first and drops any
   //   beat that was held, without answering it
   //
   // limitations
   //   one write and one read may be under way at a time; there is no
   //   queue, so throughput is one write every four cycles at best
   //   the prot inputs are ignored: every access is treated alike
   //   a write to the status word is answered okay and dropped
   //   the address field cannot be chosen by software; trading that
   //   away keeps the readback a reliable check of which word was hit
   //   outputs are registered, so an input's range moves two edges after
   //   its write beats land; software must allow for that before sampling
   //   a beat held across a write response is not lost, only delayed
   //
   // naming
   //   range_a_* ports carry inputs seven..four, range_b_* inputs three..zero
   //   status bits 2:0 hold input zero, bits 23:21 input seven

   // maps a byte address to a register select code; shared by both channels
   function [1:0] irs_decode;
      input [ADDR_W-1:0] addr;
      begin
         if (addr == `IRS_ADDR_GRP_A_UPPER)
            irs_decode = `IRS_SEL_A;
         else if (addr == `IRS_ADDR_GRP_B_LOWER)
            irs_decode = `IRS_SEL_B;
         else if (addr == `IRS_ADDR_STATUS)
            irs_decode = `IRS_SEL_STAT;
         else
            irs_decode = `IRS_SEL_NONE;
      end
   endfunction

   // turns a 2-bit code into a one-hot choice of three ranges
   function [2:0] irs_range;
      input [1:0] code;
      begin
         case (code)
            `IRS_CODE_10V_A: irs_range = `IRS_SEL_10V;   // [RULE4]
            `IRS_CODE_2V5:   irs_range = `IRS_SEL_2V5;   // [RULE4]
            `IRS_CODE_5V:    irs_range = `IRS_SEL_5V;    // [RULE4]
            default:         irs_range = `IRS_SEL_10V;   // [RULE4]
         endcase
      end
   endfunction

   // writes a 16-bit register under byte strobes, then stamps its own address
   function [15:0] irs_merge;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      input [6:0]  idx;
      reg   [15:0] tmp;
      begin
         tmp = old;
         if (strb[0])
            tmp[7:0] = data[7:0];
         if (strb[1])
            tmp[15:8] = data[15:8];
         // once written, the address field always reads back the index of the register that holds it
         tmp[`IRS_ADDR_FIELD_MSB:`IRS_ADDR_FIELD_LSB] = idx;   // [RULE3]
         irs_merge = tmp;
      end
   endfunction

   // register storage
   reg  [15:0]       range_a_reg;
   reg  [15:0]       range_b_reg;
   wire [23:0]       applied;

   // write channel holding state
   reg               aw_full_reg;
   reg  [ADDR_W-1:0] aw_addr_reg;
   reg               w_full_reg;
   reg  [31:0]       w_data_reg;
   reg  [3:0]        w_strb_reg;

   wire              aw_take = s_axi_awvalid & s_axi_awready;
   wire              w_take  = s_axi_wvalid & s_axi_wready;
   wire              ar_take = s_axi_arvalid & s_axi_arready;
   wire              do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   wire [1:0]        wr_sel = irs_decode(aw_addr_reg);
   wire [1:0]        rd_sel = irs_decode(s_axi_araddr);

   // write address and data are caught independently, in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg   <= 1'b0;
         aw_addr_reg   <= {ADDR_W{1'b0}};
         w_full_reg    <= 1'b0;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full_reg <= 1'b0;
         end
         if (w_take) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_full_reg <= 1'b0;
         end
         // ready drops for the cycle a beat lands, so each beat is held once only
         s_axi_awready <= ~aw_full_reg & ~aw_take & ~s_axi_bvalid;
         s_axi_wready  <= ~w_full_reg & ~w_take & ~s_axi_bvalid;
      end
   end

   // range registers: written once both beats are held
   always @(posedge aclk) begin
      if (!aresetn) begin
         range_a_reg <= `IRS_RANGE_RESET;   // [RULE1] [RULE3] [RULE5] [RULE7]
         range_b_reg <= `IRS_RANGE_RESET;   // [RULE2] [RULE3] [RULE6] [RULE7]
      end else if (do_write) begin
         if (wr_sel == `IRS_SEL_A)
            range_a_reg <= irs_merge(range_a_reg, w_data_reg, w_strb_reg,
                                     `IRS_IDX_GRP_A_UPPER);   // [RULE1]
         if (wr_sel == `IRS_SEL_B)
            range_b_reg <= irs_merge(range_b_reg, w_data_reg, w_strb_reg,
                                     `IRS_IDX_GRP_B_LOWER);   // [RULE2]
      end
   end

   // write response; the status word is read-only, a write there is dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IRS_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (wr_sel == `IRS_SEL_NONE)
            s_axi_bresp <= `IRS_RESP_SLVERR;
         else
            s_axi_bresp <= `IRS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: one read at a time, data one cycle after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `IRS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `IRS_RESP_OKAY;
            case (rd_sel)
               `IRS_SEL_A:    s_axi_rdata <= {16'h0000, range_a_reg};
               `IRS_SEL_B:    s_axi_rdata <= {16'h0000, range_b_reg};
               `IRS_SEL_STAT: s_axi_rdata <= {8'h00, applied};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `IRS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // applied ranges: each field drives its own input; bit 8 and the address
   // field are not looked at, so they cannot move a range
   // each field owns its flip-flops, so no vector is shared between processes
   genvar gi;
   generate
      for (gi = 0; gi < `IRS_FIELDS; gi = gi + 1) begin : g_field
         reg [2:0] b_range_reg;
         reg [2:0] a_range_reg;
         always @(posedge aclk) begin
            if (!aresetn) begin
               b_range_reg <= irs_range(`IRS_FIELD_RESET);
               a_range_reg <= irs_range(`IRS_FIELD_RESET);
            end else begin
               // group B lower inputs zero..three [RULE6] [RULE8]
               b_range_reg <= irs_range(range_b_reg[2*gi+1:2*gi]);   // [RULE7]
               // group A upper inputs four..seven [RULE5] [RULE8]
               a_range_reg <= irs_range(range_a_reg[2*gi+1:2*gi]);   // [RULE7]
            end
         end
      end
   endgenerate

   // one port per input, each straight from its flip-flops
   assign range_b_input_zero  = g_field[0].b_range_reg;
   assign range_b_input_one   = g_field[1].b_range_reg;
   assign range_b_input_two   = g_field[2].b_range_reg;
   assign range_b_input_three = g_field[3].b_range_reg;
   assign range_a_input_four  = g_field[0].a_range_reg;
   assign range_a_input_five  = g_field[1].a_range_reg;
   assign range_a_input_six   = g_field[2].a_range_reg;
   assign range_a_input_seven = g_field[3].a_range_reg;

   // status word gathers the eight applied ranges, input zero lowest
   assign applied = {g_field[3].a_range_reg, g_field[2].a_range_reg,
                     g_field[1].a_range_reg, g_field[0].a_range_reg,
                     g_field[3].b_range_reg, g_field[2].b_range_reg,
                     g_field[1].b_range_reg, g_field[0].b_range_reg};

endmodule // irs_top

// >>> irs_regs.vh
// register map, field layout, reset values and range codes of the range select bank
`ifndef IRS_REGS_VH
`define IRS_REGS_VH

// register indices as printed; byte address is four times the index
`define IRS_IDX_GRP_A_UPPER   7'h05
`define IRS_IDX_GRP_B_LOWER   7'h06
`define IRS_IDX_STATUS        7'h08
`define IRS_ADDR_GRP_A_UPPER  8'h14
`define IRS_ADDR_GRP_B_LOWER  8'h18
`define IRS_ADDR_STATUS       8'h20

// register select codes returned by the address decoder
`define IRS_SEL_NONE          2'h0
`define IRS_SEL_A             2'h1
`define IRS_SEL_B             2'h2
`define IRS_SEL_STAT          2'h3

// field layout of each 16-bit range register
`define IRS_ADDR_FIELD_MSB    15
`define IRS_ADDR_FIELD_LSB    9
`define IRS_RSVD_BIT          8
`define IRS_FIELD_W           2
`define IRS_FIELDS            4

// reset values
`define IRS_RANGE_RESET       16'h00ff
`define IRS_ADDR_FIELD_RESET  7'h00
`define IRS_FIELD_RESET       2'h3

// 2-bit range codes
`define IRS_CODE_10V_A        2'h0
`define IRS_CODE_2V5          2'h1
`define IRS_CODE_5V           2'h2
`define IRS_CODE_10V_B        2'h3

// one-hot applied range: bit2 = +/-10 V, bit1 = +/-5 V, bit0 = +/-2.5 V
`define IRS_SEL_10V           3'h4
`define IRS_SEL_5V            3'h2
`define IRS_SEL_2V5           3'h1

// axi responses
`define IRS_RESP_OKAY         2'h0
`define IRS_RESP_SLVERR       2'h2

`endif

// >>> irs_checker.sv
// assertion checker for the range select register bank
`timescale 1ns/1ps
module irs_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [2:0]  range_a_input_seven,
   input wire [2:0]  range_b_input_zero
);
   // one clock domain; reset is given per property since one must see it
   default clocking cb @(posedge aclk); endclocking
   a_bresp_held: assert property (disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
   a_rdata_held: assert property (disable iff (!aresetn) s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
   // beats are held one cycle before the write lands, so the answer is two edges on
   a_write_answer: assert property (disable iff (!aresetn) s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
   a_read_answer: assert property (disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
   a_write_blocked: assert property (disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   a_read_blocked: assert property (disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   a_seven_onehot: assert property (
      disable iff (!aresetn) $onehot(range_a_input_seven)) else $error("bad range a");
   a_zero_onehot: assert property (
      disable iff (!aresetn) $onehot(range_b_input_zero)) else $error("bad range b");
   a_reset_range: assert property (!aresetn [*3] |->
      range_a_input_seven == 3'h4 && range_b_input_zero == 3'h4) else $error("reset range");
   a_change_cause: assert property (disable iff (!aresetn)
      $changed(range_a_input_seven) |-> $past(s_axi_bvalid)) else $error("range moved alone");
   // main scenarios reached
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_range_b: cover property (disable iff (!aresetn) $changed(range_b_input_zero));
endmodule // irs_checker

bind irs_top irs_checker irs_checker_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .range_a_input_seven(range_a_input_seven), .range_b_input_zero(range_b_input_zero));

// >>> input_range_select_regs_tb_top.sv
// directed testbench for the range select register bank
`timescale 1ns/1ps
`include "irs_regs.vh"
module input_range_select_regs_tb_top;
   reg         aclk = 1'b0, aresetn = 1'b0;
   reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
   reg  [31:0] wdata = 32'h0;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [2:0]  a7, a6, a5, a4, b3, b2, b1, b0;
   reg  [31:0] rd;
   reg  [1:0]  rs;
   integer     n_errors = 0, n_compared = 0, cyc = 0, i, rlag = 0;

   always #12.5 aclk = ~aclk;

   irs_top irs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .range_a_input_seven(a7),
      .range_a_input_six(a6), .range_a_input_five(a5), .range_a_input_four(a4),
      .range_b_input_three(b3), .range_b_input_two(b2), .range_b_input_one(b1),
      .range_b_input_zero(b0));

   task end_of_test;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_errors);
         if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask

   // a hang is cut short long after the hundred or so cycles the tests need
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         n_errors = n_errors + 1;
         end_of_test;
      end
   end

   task chk(input [33:0] got, input [33:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   // expected one-hot range of a 2-bit code
   function [2:0] dec(input [1:0] c);
      dec = (c == 2'h1) ? 3'h1 : (c == 2'h2) ? 3'h2 : 3'h4;
   endfunction

   // address and data offered together, each dropped once taken
   task wr(input [7:0] a, input [15:0] d);
      begin
         awaddr <= a;
         wdata <= {16'h0000, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         @(posedge aclk);
         while (awvalid || wvalid) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            @(posedge aclk);
         end
         while (!bvalid) @(posedge aclk);
         rs = bresp;
         bready <= 1'b0;
         @(posedge aclk);
      end
   endtask

   task rdr(input [7:0] a);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= (rlag == 0);
         @(posedge aclk);
         while (!arready) @(posedge aclk);
         arvalid <= 1'b0;
         while (!rvalid) @(posedge aclk);
         // a late rready makes the answer stand for rlag + 1 extra cycles
         if (rlag != 0) begin
            repeat (rlag) @(posedge aclk);
            rready <= 1'b1;
            @(posedge aclk);
         end
         rd = rdata;
         rs = rresp;
         rready <= 1'b0;
         @(posedge aclk);
      end
   endtask

   task t_reset;
      begin
         rdr(`IRS_ADDR_GRP_A_UPPER);
         chk(rd, 32'h00ff);
         rdr(`IRS_ADDR_GRP_B_LOWER);
         chk(rd, 32'h00ff);
         chk({8'h00, a7, a6, a5, a4, b3, b2, b1, b0}, {8'h00, {8{3'h4}}});
         $display("reset values done");
      end
   endtask

   task t_codes;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            wr(`IRS_ADDR_GRP_A_UPPER, {8'h00, {4{i[1:0]}}});
            rdr(`IRS_ADDR_GRP_A_UPPER);
            chk(rd, {16'h0, 7'h05, 1'b0, {4{i[1:0]}}});
            chk({a7, a6, a5, a4}, {4{dec(i[1:0])}});
         end
         // address bits written as ones must come back as the index
         wr(`IRS_ADDR_GRP_B_LOWER, 16'hfe1b);
         rdr(`IRS_ADDR_GRP_B_LOWER);
         chk(rd, 32'h0c1b);
         chk({b3, b2, b1, b0}, {3'h4, 3'h1, 3'h2, 3'h4});
         $display("range codes done");
      end
   endtask

   task t_rsvd_unmapped;
      begin
         wr(`IRS_ADDR_GRP_A_UPPER, 16'h0156);
         rdr(`IRS_ADDR_GRP_A_UPPER);
         chk(rd, 32'h0b56);
         chk({a7, a6, a5, a4}, {3'h1, 3'h1, 3'h1, 3'h2});
         wr(8'h1c, 16'h0000);
         chk(rs, `IRS_RESP_SLVERR);
         rdr(8'h1c);
         chk({rs, rd}, {`IRS_RESP_SLVERR, 32'h0});
         rdr(`IRS_ADDR_GRP_A_UPPER);
         chk({rs, rd}, {`IRS_RESP_OKAY, 32'h0b56});
         wr(`IRS_ADDR_STATUS, 16'hffff);
         chk(rs, `IRS_RESP_OKAY);
         rlag = 3;
         rdr(`IRS_ADDR_STATUS);
         rlag = 0;
         chk({rs, rd}, {`IRS_RESP_OKAY, 32'h0024_a854});
         $display("reserved and unmapped done");
      end
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset;
      t_codes;
      t_rsvd_unmapped;
      // second reset in mid-run must restore the defaults
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset;
      end_of_test;
   end
endmodule // input_range_select_regs_tb_top
